//--- rtl/pwc_top.sv
// power mode, clock source and start logic controller with AHB-Lite slave
`timescale 1ns/100ps
// Summary of operation
// RULE1: reset selects internal RC oscillator as clock
// RULE2: RC oscillator drives watchdog, PLL, or both
// RULE3: system oscillator feeds core directly or via PLL
// RULE4: sleep gates core clock, others keep running
// RULE5: sleep holds until reset or interrupt
// RULE6: peripheral interrupts wake core from sleep
// RULE7: sleep exit only re-enables core clock
// RULE8: deep-sleep also stops oscillators and PLL
// RULE9: options keep watchdog oscillator, brownout detector
// RULE10: thirteen start pins wake from deep-sleep
// RULE11: software moves to RC oscillator before deep-sleep
// RULE12: deep power-down leaves only exit pin alive
// RULE13: 50 ns low pulse exits deep power-down
// RULE14: each start pin has own interrupt line
// RULE15: start pins act as running-mode interrupts
// RULE16: start pin wake path needs no clock
// RULE17: exit pin has 20 ns glitch filter
// RULE18: mode setting chosen, entered on wait-for-interrupt
module pwc_top (
    // clock and reset
    input  wire logic                            REF_CLK,
    input  wire logic                            RESET,
    // AHB-Lite slave
    input  wire logic                            HSEL,
    input  wire logic [31:0]                     HADDR,
    input  wire logic [1:0]                      HTRANS,
    input  wire logic                            HWRITE,
    input  wire logic [2:0]                      HSIZE,
    input  wire logic [31:0]                     HWDATA,
    input  wire logic                            HREADY,
    output logic      [31:0]                     HRDATA,
    output logic                                 HREADYOUT,
    output logic                                 HRESP,
    // processor core and interrupt controller
    input  wire logic                            SLEEP_REQ,
    input  wire logic                            INT_PENDING,
    output logic      [pwc_pkg::START_PINS-1:0]  START_IRQ,
    output logic                                 IRQ,
    // external pins
    input  wire logic [pwc_pkg::START_PINS-1:0]  START_PIN,
    input  wire logic                            DPD_EXIT_PIN,
    // clock, analog and power controls
    output pwc_pkg::pwc_clkctl_t                 CLK_CTRL,
    output logic                                 OSC_WAKE_REQ,
    output logic                                 DPD_POWER_OFF,
    output logic                                 WAKE_RESET,
    output pwc_pkg::pwc_pstate_t                 POWER_STATE
);
    localparam int NP = pwc_pkg::START_PINS;
    localparam int SW = pwc_pkg::ST_W;

    pwc_pkg::pwc_state_t       r;
    pwc_pkg::pwc_state_t       next_r;
    logic [NP-1:0]             pin_s;
    logic                      exit_s;
    logic                      dpd_fire;
    logic [NP-1:0]             pin_rise;
    logic [SW-1:0]             ev;
    logic [SW-1:0]             w1c;
    logic                      addr_ok;
    logic                      run_or_sleep;
    logic                      in_dsleep;

    // start pins cross into the clock domain
    pwc_sync #(
        .W        (NP)
    ) u_start_sync (
        .clk      (REF_CLK),
        .rst      (RESET),
        .async_in (START_PIN),
        .sync_out (pin_s)
    );

    // exit pin crossing
    pwc_sync #(
        .W        (1)
    ) u_exit_sync (
        .clk      (REF_CLK),
        .rst      (RESET),
        .async_in (DPD_EXIT_PIN),
        .sync_out (exit_s)
    );

    // RULE17: exit pin filtering
    // the filter sits in the always-on domain with the pin circuit
    pwc_wake_filter #(
        .FILT_CYC  (pwc_pkg::DPD_FILT_CYC)
    ) u_exit_filt (
        .clk       (REF_CLK),
        .rst       (RESET),
        .en        (r.pstate == pwc_pkg::P_DPD),
        .pin_level (exit_s),
        .fire      (dpd_fire)
    );

    // register read mux, fed with the already updated state
    function automatic logic [31:0] rd_mux(
        input pwc_pkg::pwc_state_t s,
        input logic [7:0]          a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            pwc_pkg::A_CLKSEL:
            begin
                d[pwc_pkg::CS_MAIN_LO +: 2] = s.main_src;
                d[pwc_pkg::CS_PLL_REF] = s.pll_ref;
                d[pwc_pkg::CS_WDT_SRC] = s.wdt_src;
            end
            pwc_pkg::A_PWRCTRL:
            begin
                d[pwc_pkg::PC_MODE_LO +: 2] = s.mode_sel;
                d[pwc_pkg::PC_KEEP_WDOSC] = s.keep_wdosc;
                d[pwc_pkg::PC_KEEP_BOD] = s.keep_bod;
                d[pwc_pkg::PC_WDOSC_RUN] = s.wdosc_run;
                d[pwc_pkg::PC_SYSOSC_RUN] = s.sysosc_run;
                d[pwc_pkg::PC_PLL_RUN] = s.pll_run;
                d[pwc_pkg::PC_BOD_RUN] = s.bod_run;
            end
            pwc_pkg::A_STARTEN:
                d[NP-1:0] = s.start_en;
            pwc_pkg::A_STATUS:
                d[SW-1:0] = s.status;
            pwc_pkg::A_MASK:
                d[SW-1:0] = s.mask;
            pwc_pkg::A_STATE:
                d[1:0] = s.pstate;
            default:
                d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // RULE15: start pins as interrupt sources in run mode
    // rising edges of enabled pins are events in every powered state
    assign pin_rise = pin_s & ~r.pin_prev & r.start_en;
    assign in_dsleep = (r.pstate == pwc_pkg::P_DSLEEP);
    assign run_or_sleep = (r.pstate == pwc_pkg::P_RUN) ||
                          (r.pstate == pwc_pkg::P_SLEEP);

    // events and write-one-to-clear bits
    always_comb
    begin
        ev = '0;
        ev[NP-1:0] = pin_rise;
        w1c = '0;
        if (r.dph_wr && (r.dph_addr == pwc_pkg::A_STATUS))
            w1c = HWDATA[SW-1:0];
        if (in_dsleep && ((|pin_rise) || INT_PENDING))
            ev[pwc_pkg::ST_DSWAKE] = 1'b1;
    end

    // word-sized accesses only
    assign addr_ok = HSEL && HREADY && HTRANS[1] && (HSIZE == 3'b010);

    // next state
    always_comb
    begin
        next_r = r;
        next_r.wake_reset = 1'b0;
        next_r.pin_prev = pin_s;

        // data phase write of the previous address phase
        if (r.dph_wr)
        begin
            case (r.dph_addr)
                pwc_pkg::A_CLKSEL:
                begin
                    // RULE2: watchdog and PLL reference choice
                    next_r.main_src = pwc_pkg::pwc_main_src_t'(
                        HWDATA[pwc_pkg::CS_MAIN_LO +: 2]);
                    next_r.pll_ref = HWDATA[pwc_pkg::CS_PLL_REF];
                    next_r.wdt_src = HWDATA[pwc_pkg::CS_WDT_SRC];
                end
                pwc_pkg::A_PWRCTRL:
                begin
                    next_r.mode_sel = pwc_pkg::pwc_mode_sel_t'(
                        HWDATA[pwc_pkg::PC_MODE_LO +: 2]);
                    // RULE9: deep-sleep keep options
                    next_r.keep_wdosc = HWDATA[pwc_pkg::PC_KEEP_WDOSC];
                    next_r.keep_bod = HWDATA[pwc_pkg::PC_KEEP_BOD];
                    next_r.wdosc_run = HWDATA[pwc_pkg::PC_WDOSC_RUN];
                    next_r.sysosc_run = HWDATA[pwc_pkg::PC_SYSOSC_RUN];
                    next_r.pll_run = HWDATA[pwc_pkg::PC_PLL_RUN];
                    next_r.bod_run = HWDATA[pwc_pkg::PC_BOD_RUN];
                end
                pwc_pkg::A_STARTEN:
                    next_r.start_en = HWDATA[NP-1:0];
                pwc_pkg::A_MASK:
                    next_r.mask = HWDATA[SW-1:0];
                default:
                    next_r.start_en = r.start_en;
            endcase
        end

        // sticky status: a new event beats a clear in the same cycle
        next_r.status = (r.status & ~w1c) | ev;

        // power state machine
        unique case (r.pstate)
            pwc_pkg::P_RUN:
            begin
                // RULE18: wait-for-interrupt enters the chosen mode
                // a pending interrupt makes the wait fall through
                if (SLEEP_REQ && !INT_PENDING)
                begin
                    unique case (r.mode_sel)
                        pwc_pkg::SEL_DSLEEP:
                            next_r.pstate = pwc_pkg::P_DSLEEP;
                        pwc_pkg::SEL_DPD:
                            next_r.pstate = pwc_pkg::P_DPD;
                        pwc_pkg::SEL_SLEEP,
                        pwc_pkg::SEL_RSVD:
                            next_r.pstate = pwc_pkg::P_SLEEP;
                    endcase
                end
            end
            pwc_pkg::P_SLEEP:
            begin
                // RULE5: only an interrupt resumes; reset also does
                // RULE6: peripheral interrupts wake the core
                // RULE7: direct return, no handshake stage
                if (INT_PENDING)
                    next_r.pstate = pwc_pkg::P_RUN;
            end
            pwc_pkg::P_DSLEEP:
            begin
                // RULE10: any enabled start pin ends deep-sleep
                if ((|pin_rise) || INT_PENDING)
                    next_r.pstate = pwc_pkg::P_RUN;
            end
            pwc_pkg::P_DPD:
            begin
                // RULE12: only the exit pin leaves power-down
                // RULE13: filtered low pulse restarts the chip
                if (dpd_fire)
                begin
                    next_r.pstate = pwc_pkg::P_RUN;
                    next_r.wake_reset = 1'b1;
                end
            end
        endcase

        // address phase capture; read data taken after any write
        next_r.dph_wr = addr_ok && HWRITE;
        next_r.dph_rd = addr_ok && !HWRITE;
        next_r.dph_addr = addr_ok ? HADDR[7:0] : r.dph_addr;
        if (addr_ok && !HWRITE)
            next_r.rdata = rd_mux(next_r, HADDR[7:0]);
    end

    // state register
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            r <= '0;
            // RULE1: run from the RC oscillator after reset
            r.main_src <= pwc_pkg::pwc_main_src_t'(
                pwc_pkg::CLKSEL_RST[pwc_pkg::CS_MAIN_LO +: 2]);
            r.pll_ref <= pwc_pkg::CLKSEL_RST[pwc_pkg::CS_PLL_REF];
            r.wdt_src <= pwc_pkg::CLKSEL_RST[pwc_pkg::CS_WDT_SRC];
            r.bod_run <= pwc_pkg::PWRCTRL_RST[pwc_pkg::PC_BOD_RUN];
            r.pin_prev <= '1;
            r.pstate <= pwc_pkg::P_RUN;
            r.mode_sel <= pwc_pkg::SEL_SLEEP;
        end
        else
            r <= next_r;
    end

    // bus answers: zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = r.rdata;

    // RULE14: one interrupt line per start pin
    assign START_IRQ = r.status[NP-1:0] & r.mask[NP-1:0];
    assign IRQ = |(r.status & r.mask);

    // clock source routing
    always_comb
    begin
        // RULE3: system oscillator direct or through the PLL
        CLK_CTRL.main_src = r.main_src;
        CLK_CTRL.pll_ref_sysosc = r.pll_ref;
        CLK_CTRL.wdt_src_wdosc = r.wdt_src;
        // RULE4: core clock only in run
        CLK_CTRL.core_clk_en = (r.pstate == pwc_pkg::P_RUN);
        // RULE8: deep-sleep shuts the RC and system oscillators and the PLL
        CLK_CTRL.irc_en = run_or_sleep;
        CLK_CTRL.sysosc_en = run_or_sleep && r.sysosc_run;
        CLK_CTRL.pll_en = run_or_sleep && r.pll_run;
        // RULE9: optional survivors in deep-sleep
        CLK_CTRL.wdosc_en = (run_or_sleep && r.wdosc_run) ||
                            (in_dsleep && r.keep_wdosc);
        CLK_CTRL.bod_en = (run_or_sleep && r.bod_run) ||
                          (in_dsleep && r.keep_bod);
    end

    // RULE16: clockless wake request from the raw pins
    // oscillators are off here, so the sampled path cannot start them
    assign OSC_WAKE_REQ = in_dsleep &&
                          |(START_PIN & r.start_en & ~r.pin_prev);

    // RULE12: core power removed in deep power-down
    assign DPD_POWER_OFF = (r.pstate == pwc_pkg::P_DPD);
    assign WAKE_RESET = r.wake_reset;
    assign POWER_STATE = r.pstate;
endmodule

//--- rtl/pwc_pkg.sv
// shared constants and types of the power mode and wake controller
package pwc_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] A_CLKSEL  = 8'h00;
    localparam logic [7:0] A_PWRCTRL = 8'h04;
    localparam logic [7:0] A_STARTEN = 8'h08;
    localparam logic [7:0] A_STATUS  = 8'h0C;
    localparam logic [7:0] A_MASK    = 8'h10;
    localparam logic [7:0] A_STATE   = 8'h14;

    // start logic width and status layout
    localparam int START_PINS = 13;
    localparam int ST_DSWAKE  = 13;
    localparam int ST_W       = 14;

    // clksel fields
    localparam int CS_MAIN_LO = 0;
    localparam int CS_PLL_REF = 2;
    localparam int CS_WDT_SRC = 4;

    // pwrctrl fields
    localparam int PC_MODE_LO    = 0;
    localparam int PC_KEEP_WDOSC = 4;
    localparam int PC_KEEP_BOD   = 5;
    localparam int PC_WDOSC_RUN  = 8;
    localparam int PC_SYSOSC_RUN = 9;
    localparam int PC_PLL_RUN    = 10;
    localparam int PC_BOD_RUN    = 11;

    // reset values
    localparam logic [31:0] CLKSEL_RST  = 32'h0000_0000;
    localparam logic [31:0] PWRCTRL_RST = 32'h0000_0800;

    // timing: nominal oscillator rate and wake pin figures
    localparam int IRC_NOMINAL_MHZ  = 12;
    localparam int REF_CLK_MHZ      = 200;
    localparam int DPD_FILT_NS      = 20;
    localparam int DPD_MIN_PULSE_NS = 50;
    // glitch window, longest time so rounded down, at least one cycle
    localparam int DPD_FILT_CYC_RAW = DPD_FILT_NS * REF_CLK_MHZ / 1000;
    localparam int DPD_FILT_CYC     =
        (DPD_FILT_CYC_RAW < 1) ? 1 : DPD_FILT_CYC_RAW;

    // main clock source codes
    typedef enum logic [1:0] {
        MAIN_IRC    = 2'b00,
        MAIN_PLL    = 2'b01,
        MAIN_SYSOSC = 2'b10,
        MAIN_WDOSC  = 2'b11
    } pwc_main_src_t;

    // low power mode chosen for the next wait-for-interrupt
    typedef enum logic [1:0] {
        SEL_SLEEP  = 2'b00,
        SEL_DSLEEP = 2'b01,
        SEL_DPD    = 2'b10,
        SEL_RSVD   = 2'b11
    } pwc_mode_sel_t;

    // power state
    typedef enum logic [1:0] {
        P_RUN    = 2'b00,
        P_SLEEP  = 2'b01,
        P_DSLEEP = 2'b10,
        P_DPD    = 2'b11
    } pwc_pstate_t;

    // clock and analog controls leaving the block
    typedef struct packed {
        logic          core_clk_en;
        pwc_main_src_t main_src;
        logic          pll_ref_sysosc;
        logic          wdt_src_wdosc;
        logic          irc_en;
        logic          sysosc_en;
        logic          pll_en;
        logic          wdosc_en;
        logic          bod_en;
    } pwc_clkctl_t;

    // whole state of the top module
    typedef struct packed {
        pwc_pstate_t             pstate;
        pwc_main_src_t           main_src;
        logic                    pll_ref;
        logic                    wdt_src;
        pwc_mode_sel_t           mode_sel;
        logic                    keep_wdosc;
        logic                    keep_bod;
        logic                    wdosc_run;
        logic                    sysosc_run;
        logic                    pll_run;
        logic                    bod_run;
        logic [START_PINS-1:0]   start_en;
        logic [ST_W-1:0]         status;
        logic [ST_W-1:0]         mask;
        logic [START_PINS-1:0]   pin_prev;
        logic                    dph_wr;
        logic                    dph_rd;
        logic [7:0]              dph_addr;
        logic [31:0]             rdata;
        logic                    wake_reset;
    } pwc_state_t;

endpackage

//--- rtl/pwc_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module pwc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pwc_sync_st_t;

    pwc_sync_st_t r;
    pwc_sync_st_t next_r;

    // first stage feeds only the second
    always_comb
    begin
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
    end

    // pins idle high through pull-ups
    always_ff @(posedge clk)
    begin
        if (rst)
            r <= '1;
        else
            r <= next_r;
    end

    assign sync_out = r.s2;
endmodule

//--- rtl/pwc_wake_filter.sv
// low pulse detector with glitch rejection for the power-down exit pin
`timescale 1ns/100ps
module pwc_wake_filter #(
    parameter int FILT_CYC = 4
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control and pin level, already synchronised
    input  wire logic en,
    input  wire logic pin_level,
    // one-cycle wake pulse
    output logic      fire
);
    localparam int CW = $clog2(FILT_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

    typedef struct packed {
        logic          armed;
        logic [CW-1:0] cnt;
        logic          fire;
    } pwc_filt_st_t;

    pwc_filt_st_t r;
    pwc_filt_st_t next_r;

    // arm on a high level, fire after enough low samples in a row
    always_comb
    begin
        next_r = r;
        next_r.fire = 1'b0;
        if (!en)
        begin
            next_r.armed = 1'b0;
            next_r.cnt = '0;
        end
        else if (pin_level)
        begin
            next_r.armed = 1'b1;
            next_r.cnt = '0;
        end
        else if (r.armed)
        begin
            // shorter low glitches restart the count
            if (r.cnt == LAST)
            begin
                next_r.fire = 1'b1;
                next_r.armed = 1'b0;
                next_r.cnt = '0;
            end
            else
                next_r.cnt = r.cnt + CW'(1);
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign fire = r.fire;
endmodule

//--- tb/pwc_top_chk.sv
// assertion checker for the power mode and wake controller
`timescale 1ns/100ps
module pwc_top_chk (
    // clock and reset
    input wire logic                 REF_CLK,
    input wire logic                 RESET,
    // core and interrupt side
    input wire logic                 SLEEP_REQ,
    input wire logic                 INT_PENDING,
    input wire logic [12:0]          START_IRQ,
    input wire logic                 IRQ,
    // pins and controls
    input wire logic                 DPD_EXIT_PIN,
    input wire pwc_pkg::pwc_clkctl_t CLK_CTRL,
    input wire logic                 DPD_POWER_OFF,
    input wire logic                 WAKE_RESET,
    input wire pwc_pkg::pwc_pstate_t POWER_STATE
);
    default clocking dc @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    // clock source and sleep entry or exit
    irc_reset_a: assert property (
        $fell(RESET) |-> CLK_CTRL.main_src == 2'h0 && CLK_CTRL.irc_en)
        else $error("clock source not rc after reset");
    sleep_enter_a: assert property (
        POWER_STATE == 2'h0 && SLEEP_REQ && !INT_PENDING
        |=> POWER_STATE != 2'h0)
        else $error("wait for interrupt not taken");
    sleep_gate_a: assert property (
        POWER_STATE == 2'h1 |-> !CLK_CTRL.core_clk_en && CLK_CTRL.irc_en)
        else $error("sleep clock gating wrong");
    sleep_hold_a: assert property (
        POWER_STATE == 2'h1 && !INT_PENDING |=> POWER_STATE == 2'h1)
        else $error("sleep left without a cause");
    sleep_exit_a: assert property (
        POWER_STATE == 2'h1 && INT_PENDING
        |=> POWER_STATE == 2'h0 && CLK_CTRL.core_clk_en)
        else $error("sleep exit not one cycle");

    // deep modes; the glitch check waits out the synchroniser
    dsleep_analog_a: assert property (
        POWER_STATE == 2'h2 |-> !CLK_CTRL.core_clk_en && !CLK_CTRL.irc_en
        && !CLK_CTRL.sysosc_en && !CLK_CTRL.pll_en)
        else $error("analog blocks on in deep sleep");
    dpd_off_a: assert property (
        DPD_POWER_OFF == (POWER_STATE == 2'h3))
        else $error("power off flag wrong");
    dpd_glitch_a: assert property (
        (POWER_STATE == 2'h3 && DPD_EXIT_PIN) [*4] |=> POWER_STATE == 2'h3)
        else $error("power down left with pin high");
    wake_pulse_a: assert property (
        $fell(DPD_POWER_OFF) |-> ##[0:1] WAKE_RESET ##1 !WAKE_RESET)
        else $error("wake reset pulse wrong");
    irq_line_a: assert property (
        START_IRQ != 13'h0 |-> IRQ)
        else $error("start interrupt without irq");
endmodule

bind pwc_top pwc_top_chk u_chk (
    .REF_CLK, .RESET, .SLEEP_REQ, .INT_PENDING, .START_IRQ, .IRQ,
    .DPD_EXIT_PIN, .CLK_CTRL, .DPD_POWER_OFF, .WAKE_RESET, .POWER_STATE
);

//--- tb/pwc_core_model.sv
// behavioural core, interrupt source and wake pins around the controller
`timescale 1ns/100ps
module pwc_core_model (
    // clock
    input  wire logic   clk,
    // core and interrupt controller
    output logic        sleep_req,
    output logic        int_pend,
    // external pins
    output logic [12:0] start_pin,
    output logic        exit_pin
);
    // idle levels, exit pin held high by its pull-up
    initial
    begin
        sleep_req = 1'h0;
        int_pend = 1'h0;
        start_pin = 13'h0;
        exit_pin = 1'h1;
    end

    task automatic wfi();
        @(posedge clk);
        sleep_req <= 1'h1;
        @(posedge clk);
        sleep_req <= 1'h0;
    endtask

    task automatic irq(input logic v);
        @(posedge clk);
        int_pend <= v;
    endtask

    task automatic pin(input int i, input logic v);
        @(posedge clk);
        start_pin[i] <= v;
    endtask

    // low pulse on the exit pin, n cycles long
    task automatic pulse(input int n);
        @(posedge clk);
        exit_pin <= 1'h0;
        repeat (n) @(posedge clk);
        exit_pin <= 1'h1;
    endtask
endmodule

//--- tb/test_pwc_top.sv
// self-checking bench for the power mode and wake controller
`timescale 1ns/100ps
module test_pwc_top;
    logic                 clk;
    logic                 rst;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic                 hwrite;
    logic [31:0]          hwdata;
    logic [31:0]          rd;
    logic [31:0]          seed;
    wire logic [31:0]     hrdata;
    wire logic            hready;
    wire logic            hresp;
    wire logic            sleep_req;
    wire logic            int_pend;
    wire logic [12:0]     start_pin;
    wire logic            exit_pin;
    wire logic [12:0]     start_irq;
    wire logic            irq;
    wire logic            osc_wake;
    wire logic            pwr_off;
    wire logic            wake_rst;
    pwc_pkg::pwc_clkctl_t ctl;
    pwc_pkg::pwc_pstate_t pst;
    int                   mismatches;
    int                   comparisons;
    int                   n;
    int                   j;
    // register model by word offset, with writable bits
    int                   mdl [6];
    localparam int        WM [6] = '{'h17, 'hF33, 'h1FFF, 0, 'h3FFF, 0};

    pwc_top DUT (
        .REF_CLK      (clk),
        .RESET        (rst),
        .HSEL         (hsel),
        .HADDR        (haddr),
        .HTRANS       (htrans),
        .HWRITE       (hwrite),
        .HSIZE        (hsize),
        .HWDATA       (hwdata),
        .HREADY       (hready),
        .HRDATA       (hrdata),
        .HREADYOUT    (hready),
        .HRESP        (hresp),
        .SLEEP_REQ    (sleep_req),
        .INT_PENDING  (int_pend),
        .START_IRQ    (start_irq),
        .IRQ          (irq),
        .START_PIN    (start_pin),
        .DPD_EXIT_PIN (exit_pin),
        .CLK_CTRL     (ctl),
        .OSC_WAKE_REQ (osc_wake),
        .DPD_POWER_OFF(pwr_off),
        .WAKE_RESET   (wake_rst),
        .POWER_STATE  (pst)
    );

    pwc_core_model core (
        .clk      (clk),
        .sleep_req(sleep_req),
        .int_pend (int_pend),
        .start_pin(start_pin),
        .exit_pin (exit_pin)
    );

    // 200 MHz clock
    always #2.5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one word transfer; no wait count assumed, the watchdog bounds it
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
        if (w && a == 8'h0C)
            mdl[3] &= ~d;
        else if (w && a < 8'h18)
            mdl[a[7:2]] = d & WM[a[7:2]];
    endtask

    task automatic rdchk(input logic [7:0] a);
        bus(1'h0, a, 32'h0);
        check(rd, a < 8'h18 ? mdl[a[7:2]] : 0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog against a hung wait
    initial
    begin
        repeat (6000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    // main sequence
    initial
    begin
        clk = 1'h0;
        rst = 1'h1;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        seed = 32'h32;
        mismatches = 0;
        comparisons = 0;
        mdl = '{0, 'h800, 0, 0, 0, 0};
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        check({hresp, ctl[9:4]}, 7'h21);
        for (int i = 0; i < 7; i++)
            rdchk(8'(i * 4));
        for (int i = 0; i < 4; i++)
        begin
            bus(1'h1, 8'h00, (rnd() & 32'h14) | i);
            rdchk(8'h00);
            check(ctl[9:4], {1'h1, mdl[0][1:0], mdl[0][2],
                             mdl[0][4], 1'h1});
        end
        // sleep refused with an interrupt pending, then taken
        bus(1'h1, 8'h04, 32'h800);
        core.irq(1'h1);
        core.wfi();
        tick(1);
        check(pst, 2'h0);
        core.irq(1'h0);
        core.wfi();
        tick(3);
        check({pst, ctl[9], ctl[4]}, 4'h5);
        core.irq(1'h1);
        tick(1);
        check({pst, ctl[9]}, 3'h1);
        core.irq(1'h0);
        // each start pin as a running interrupt, random mask
        bus(1'h1, 8'h08, 32'h1FFF);
        bus(1'h1, 8'h10, rnd());
        for (int i = 0; i < 13; i++)
        begin
            core.pin(i, 1'h1);
            tick(5);
            mdl[3] |= 1 << i;
            check(start_irq, mdl[3] & mdl[4] & 'h1FFF);
            check(irq, |(mdl[3] & mdl[4]));
            rdchk(8'h0C);
            bus(1'h1, 8'h0C, 32'h1 << i);
            core.pin(i, 1'h0);
        end
        // deep sleep with and without the keep options
        for (int k = 0; k < 2; k++)
        begin
            bus(1'h1, 8'h00, 32'h0);
            bus(1'h1, 8'h04, k ? 32'hF31 : 32'hF01);
            core.wfi();
            tick(1);
            check({pst, ctl}, {6'h20, 4'h0, k[0], k[0]});
            j = rnd() % 13;
            core.pin(j, 1'h1);
            #1;
            check(osc_wake, 1'h1);
            tick(6);
            mdl[3] |= (1 << j) | 'h2000;
            check(pst, 2'h0);
            rdchk(8'h0C);
            bus(1'h1, 8'h0C, 32'h3FFF);
            core.pin(j, 1'h0);
        end
        // deep power-down: a glitch is ignored, a long pulse wakes
        bus(1'h1, 8'h04, 32'h802);
        core.wfi();
        tick(2);
        check({pst, pwr_off}, 3'h7);
        core.pulse(2);
        tick(10);
        check(pst, 2'h3);
        fork
            core.pulse(10);
        join_none
        n = 0;
        while (wake_rst !== 1'h1 && n < 20)
        begin
            tick(1);
            n++;
        end
        check(n < 20, 1'h1);
        tick(2);
        check({pst, pwr_off}, 3'h0);
        finish_test();
    end
endmodule
